// ==== inc/mae_pkg.sv ====
/*
  Constants for the multiply-accumulate engine: register addresses, field
  positions, reset values and datapath widths.
  Assumes an 8-bit special-function-register bus on the single system clock.
*/
`default_nettype none
// Behaviour
// - shift request shifts the accumulator next cycle, then clears
// - shift direction bit: 0 shifts left, 1 shifts right
// - clear bit zeroes accumulator, resets flags next cycle, then clears
// - sat bit saturates rounded result on overflow, never the accumulator
// - format bit: 0 signed integer, 1 signed fractional operands
// - operation bit: 0 accumulates product, 1 product replaces accumulator
// - configuration bits 7-6 read zero and ignore writes
// - sticky hard flag sets on top byte 0x7f/0x80 crossing in accumulate
// - zero flag follows whether the operation left the accumulator zero
// - soft overflow flag tracks overflow into bit 31, clears when fixed
// - negative flag follows the accumulator sign after an operation
// - status bits 7-4 read zero and ignore writes
// - accumulator seen as four low bytes plus a top byte for bits 39-32
// - each operand held as high byte (bits 15-8) and low byte
// - B low write: stage 1 multiplies, 2 adds, 3 rounds; restart in 1
// - right shift is arithmetic from bit 39; shifts leave flags unchanged
// - round bits 31-16: above 0x8000 up, below down, tie up only if odd
// - saturated rounding shows 0x7fff positive and 0x8000 negative
package mae_pkg;

  localparam int ACC_W  = 40;
  localparam int OPD_W  = 16;
  localparam int PROD_W = 32;
  localparam int RND_W  = 16;
  localparam int ACC_BYTES = 5;

  // register addresses
  localparam logic [7:0] ADDR_ACC0   = 8'h93;
  localparam logic [7:0] ADDR_ACC1   = 8'h94;
  localparam logic [7:0] ADDR_ACC2   = 8'h95;
  localparam logic [7:0] ADDR_ACC3   = 8'h96;
  localparam logic [7:0] ADDR_TOP    = 8'h97;
  localparam logic [7:0] ADDR_STATUS = 8'hc0;
  localparam logic [7:0] ADDR_AL     = 8'hc1;
  localparam logic [7:0] ADDR_AH     = 8'hc2;
  localparam logic [7:0] ADDR_CFG    = 8'hc3;
  localparam logic [7:0] ADDR_BH     = 8'hc4;
  localparam logic [7:0] ADDR_BL     = 8'hc5;
  localparam logic [7:0] ADDR_RNDL   = 8'hce;
  localparam logic [7:0] ADDR_RNDH   = 8'hcf;

  // accumulator byte addresses, byte 0 in the low slot
  localparam logic [ACC_BYTES-1:0][7:0] ACC_ADDRS =
    {ADDR_TOP, ADDR_ACC3, ADDR_ACC2, ADDR_ACC1, ADDR_ACC0};

  // configuration fields
  localparam int CFG_SHIFT_REQ = 5;
  localparam int CFG_SHIFT_DIR = 4;
  localparam int CFG_CLEAR     = 3;
  localparam int CFG_SAT       = 2;
  localparam int CFG_FRAC      = 1;
  localparam int CFG_MULONLY   = 0;
  localparam int CFG_W         = 6;

  // status fields
  localparam int STA_HARD = 3;
  localparam int STA_ZERO = 2;
  localparam int STA_SOFT = 1;
  localparam int STA_NEG  = 0;
  localparam int STA_W    = 4;

  // reset values
  localparam logic [CFG_W-1:0] CFG_RESET     = 6'h00;
  localparam logic [STA_W-1:0] STA_RESET     = 4'h4;
  localparam logic [OPD_W-1:0] OPERAND_RESET = 16'h0000;
  localparam logic [ACC_W-1:0] ACC_RESET     = 40'h00_0000_0000;
  localparam logic [RND_W-1:0] RND_RESET     = 16'h0000;
  localparam logic [7:0]       RDATA_RESET   = 8'h00;

  // unused upper bits
  localparam logic [1:0] CFG_PAD = 2'h0;
  localparam logic [3:0] STA_PAD = 4'h0;

  // overflow and rounding figures
  localparam logic [7:0]       TOP_POS_MAX = 8'h7f;
  localparam logic [7:0]       TOP_NEG_MIN = 8'h80;
  localparam logic [RND_W-1:0] ROUND_HALF  = 16'h8000;
  localparam logic [RND_W-1:0] SAT_POS     = 16'h7fff;
  localparam logic [RND_W-1:0] SAT_NEG     = 16'h8000;

endpackage
`default_nettype wire

// ==== src/mae_round.sv ====
/*
  Rounding and saturation stage of the multiply-accumulate engine.
  Assumes the caller pulses load one cycle after the accumulator settles.
*/
`timescale 1ns/1ps
`default_nettype none
module mae_round #(
  parameter int ACC_W = 40,
  parameter int RND_W = 16
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // control
  input  wire logic             load,
  input  wire logic             satEnable,
  input  wire logic [ACC_W-1:0] accValue,
  // result
  output var  logic [RND_W-1:0] rounded
);

  localparam int HI_W = ACC_W - RND_W;

  logic [RND_W-1:0] fracPart;
  logic             roundUp;
  logic [HI_W-1:0]  upperSum;
  logic             overflow;
  logic [RND_W-1:0] rounded_next;

  // tie rounds toward even upper word
  always_comb begin
    fracPart = accValue[RND_W-1:0];
    roundUp  = (fracPart > mae_pkg::ROUND_HALF) ||
               ((fracPart == mae_pkg::ROUND_HALF) && accValue[RND_W]);
    upperSum = accValue[ACC_W-1:RND_W] + HI_W'(roundUp);
    // out of range when bits above the result sign disagree with it
    overflow = !((&upperSum[HI_W-1:RND_W-1]) ||
                 (~|upperSum[HI_W-1:RND_W-1]));
    if (satEnable && overflow) begin
      rounded_next = upperSum[HI_W-1] ? mae_pkg::SAT_NEG
                                      : mae_pkg::SAT_POS;
    end else begin
      rounded_next = upperSum[RND_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rounded <= mae_pkg::RND_RESET;
    end else if (load) begin
      rounded <= rounded_next;
    end
  end

endmodule
`default_nettype wire

// ==== src/mae_engine.sv ====
/*
  Multiply-accumulate engine with its register file on the core's
  special-function-register bus: operands, configuration, status,
  a 40-bit accumulator and rounded result registers.
  Assumes the core drives the bus on the same system clock, with one-cycle
  write and read strobes, and that it reads data one cycle after the strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module mae_engine #(
  parameter int ACC_W = mae_pkg::ACC_W,
  parameter int OPD_W = mae_pkg::OPD_W
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // register bus
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrite,
  input  wire logic       sfrRead,
  input  wire logic [7:0] sfrWdata,
  output var  logic [7:0] sfrRdata
);

  localparam int PROD_W = 2 * OPD_W;
  localparam int NBYTES = ACC_W / 8;

  // stored state
  logic [OPD_W-1:0]         opA_reg;
  logic [OPD_W-1:0]         opB_reg;
  logic [mae_pkg::CFG_W-1:0] cfg_reg;
  logic [mae_pkg::CFG_W-1:0] cfg_next;
  logic [mae_pkg::STA_W-1:0] sta_reg;
  logic [mae_pkg::STA_W-1:0] sta_next;
  logic [ACC_W-1:0]         acc_reg;
  logic [ACC_W-1:0]         acc_next;
  logic [ACC_W-1:0]         prod_reg;
  logic                     stage1_reg;
  logic                     stage2_reg;
  logic                     stage3_reg;
  logic                     shiftDone_reg;
  logic                     acc0Wr_reg;
  logic [7:0]               rdata_reg;
  logic [7:0]               readValue;

  // decoded strobes
  logic              wrAl;
  logic              wrAh;
  logic              wrBl;
  logic              wrBh;
  logic              wrCfg;
  logic              wrSta;
  logic [NBYTES-1:0] accByteWe;
  logic [ACC_W-1:0]  accSoftware;

  // datapath
  logic signed [PROD_W-1:0] product;
  logic [ACC_W-1:0]         productExt;
  logic [ACC_W-1:0]         accBase;
  logic [ACC_W-1:0]         sum;
  logic [ACC_W-1:0]         shifted;
  logic                     hardSet;
  logic                     softOver;
  logic                     doClear;
  logic                     doShift;
  logic                     roundLoad;
  logic [15:0]              rounded;

  // write decode
  always_comb begin
    wrAl  = sfrWrite && (sfrAddr == mae_pkg::ADDR_AL);
    wrAh  = sfrWrite && (sfrAddr == mae_pkg::ADDR_AH);
    wrBh  = sfrWrite && (sfrAddr == mae_pkg::ADDR_BH);
    wrBl  = sfrWrite && (sfrAddr == mae_pkg::ADDR_BL);
    wrCfg = sfrWrite && (sfrAddr == mae_pkg::ADDR_CFG);
    wrSta = sfrWrite && (sfrAddr == mae_pkg::ADDR_STATUS);
  end

  // per-byte accumulator write path
  for (genvar i = 0; i < NBYTES; i++) begin : g_accByte
    assign accByteWe[i] = sfrWrite &&
                          (sfrAddr == mae_pkg::ACC_ADDRS[i]);
    assign accSoftware[8*i +: 8] = accByteWe[i] ? sfrWdata
                                                : acc_reg[8*i +: 8];
  end

  // operand registers, high byte holds bits 15-8
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      opA_reg <= mae_pkg::OPERAND_RESET;
    end else if (wrAh) begin
      opA_reg[15:8] <= sfrWdata;
    end else if (wrAl) begin
      opA_reg[7:0] <= sfrWdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      opB_reg <= mae_pkg::OPERAND_RESET;
    end else if (wrBh) begin
      opB_reg[15:8] <= sfrWdata;
    end else if (wrBl) begin
      opB_reg[7:0] <= sfrWdata;
    end
  end

  // pipeline sequencing: multiply, accumulate, round
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
      stage3_reg <= 1'b0;
    end else begin
      stage1_reg <= wrBl;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // stage one: signed multiply, fractional mode drops the extra sign bit
  always_comb begin
    product    = $signed(opA_reg) * $signed(opB_reg);
    productExt = {{(ACC_W-PROD_W){product[PROD_W-1]}}, product};
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      prod_reg <= mae_pkg::ACC_RESET;
    end else if (stage1_reg) begin
      if (cfg_reg[mae_pkg::CFG_FRAC]) begin
        prod_reg <= {productExt[ACC_W-2:0], 1'b0};
      end else begin
        prod_reg <= productExt;
      end
    end
  end

  // stage two arithmetic and flag conditions
  always_comb begin
    accBase = cfg_reg[mae_pkg::CFG_MULONLY] ? mae_pkg::ACC_RESET
                                            : acc_reg;
    sum     = accBase + prod_reg;
    hardSet = !cfg_reg[mae_pkg::CFG_MULONLY] &&
              (((acc_reg[39:32] == mae_pkg::TOP_POS_MAX) &&
                (sum[39:32] == mae_pkg::TOP_NEG_MIN)) ||
               ((acc_reg[39:32] == mae_pkg::TOP_NEG_MIN) &&
                (sum[39:32] == mae_pkg::TOP_POS_MAX)));
    // bits 39-31 all equal means the value still fits below the sign bit
    softOver = !((&sum[39:31]) || (~|sum[39:31]));
  end

  // one-bit shift, right shift copies bit 39
  always_comb begin
    if (cfg_reg[mae_pkg::CFG_SHIFT_DIR]) begin
      shifted = {acc_reg[ACC_W-1], acc_reg[ACC_W-1:1]};
    end else begin
      shifted = {acc_reg[ACC_W-2:0], 1'b0};
    end
    doClear = cfg_reg[mae_pkg::CFG_CLEAR];
    doShift = cfg_reg[mae_pkg::CFG_SHIFT_REQ];
  end

  // accumulator: clear over accumulate over shift over software bytes
  always_comb begin
    if (doClear) begin
      acc_next = mae_pkg::ACC_RESET;
    end else if (stage2_reg) begin
      acc_next = sum;
    end else if (doShift) begin
      acc_next = shifted;
    end else if (|accByteWe) begin
      acc_next = accSoftware;
    end else begin
      acc_next = acc_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      acc_reg <= mae_pkg::ACC_RESET;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // configuration: request bits self-clear after their action cycle
  always_comb begin
    cfg_next = cfg_reg;
    if (doShift) begin
      cfg_next[mae_pkg::CFG_SHIFT_REQ] = 1'b0;
    end
    if (doClear) begin
      cfg_next[mae_pkg::CFG_CLEAR] = 1'b0;
    end
    // a fresh write re-arms a request even while it is being retired
    if (wrCfg) begin
      cfg_next = sfrWdata[mae_pkg::CFG_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cfg_reg <= mae_pkg::CFG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // status flags: only accumulate stage, clear and software touch them
  always_comb begin
    sta_next = sta_reg;
    if (wrSta) begin
      sta_next = sfrWdata[mae_pkg::STA_W-1:0];
    end
    if (stage2_reg) begin
      sta_next[mae_pkg::STA_ZERO] = (sum == mae_pkg::ACC_RESET);
      sta_next[mae_pkg::STA_SOFT] = softOver;
      sta_next[mae_pkg::STA_NEG]  = sum[ACC_W-1];
    end
    // hardware setting of hard overflow wins over a software clear
    if (stage2_reg && hardSet) begin
      sta_next[mae_pkg::STA_HARD] = 1'b1;
    end
    if (doClear) begin
      sta_next = mae_pkg::STA_RESET;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sta_reg <= mae_pkg::STA_RESET;
    end else begin
      sta_reg <= sta_next;
    end
  end

  // rounding follows stage two, a shift, or a low accumulator byte write
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      shiftDone_reg <= 1'b0;
      acc0Wr_reg    <= 1'b0;
    end else begin
      shiftDone_reg <= doShift && !doClear && !stage2_reg;
      acc0Wr_reg    <= accByteWe[0];
    end
  end

  assign roundLoad = stage3_reg || shiftDone_reg || acc0Wr_reg;

  mae_round #(
    .ACC_W (ACC_W),
    .RND_W (mae_pkg::RND_W)
  ) u_round (
    .clock     (clock),
    .rst_b     (rst_b),
    .load      (roundLoad),
    .satEnable (cfg_reg[mae_pkg::CFG_SAT]),
    .accValue  (acc_reg),
    .rounded   (rounded)
  );

  // read multiplexer, unmapped addresses read zero
  always_comb begin
    case (sfrAddr)
      mae_pkg::ADDR_ACC0:   readValue = acc_reg[7:0];
      mae_pkg::ADDR_ACC1:   readValue = acc_reg[15:8];
      mae_pkg::ADDR_ACC2:   readValue = acc_reg[23:16];
      mae_pkg::ADDR_ACC3:   readValue = acc_reg[31:24];
      mae_pkg::ADDR_TOP:    readValue = acc_reg[39:32];
      mae_pkg::ADDR_STATUS: readValue = {mae_pkg::STA_PAD, sta_reg};
      mae_pkg::ADDR_AL:     readValue = opA_reg[7:0];
      mae_pkg::ADDR_AH:     readValue = opA_reg[15:8];
      mae_pkg::ADDR_CFG:    readValue = {mae_pkg::CFG_PAD, cfg_reg};
      mae_pkg::ADDR_BH:     readValue = opB_reg[15:8];
      mae_pkg::ADDR_BL:     readValue = opB_reg[7:0];
      mae_pkg::ADDR_RNDL:   readValue = rounded[7:0];
      mae_pkg::ADDR_RNDH:   readValue = rounded[15:8];
      default:              readValue = mae_pkg::RDATA_RESET;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rdata_reg <= mae_pkg::RDATA_RESET;
    end else if (sfrRead) begin
      rdata_reg <= readValue;
    end
  end

  assign sfrRdata = rdata_reg;

endmodule
`default_nettype wire

// ==== dv/mae_engine_asserts.sv ====
/*
  Checker for the multiply-accumulate engine register bus.
  Assumes it is bound to mae_engine and that read data follows the strobe
  by one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module mae_engine_asserts (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst_b,
  // register bus
  input wire logic [7:0] sfrAddr,
  input wire logic       sfrWrite,
  input wire logic       sfrRead,
  input wire logic [7:0] sfrWdata,
  input wire logic [7:0] sfrRdata
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence rdCfg;
    sfrRead && !sfrWrite && sfrAddr == mae_pkg::ADDR_CFG;
  endsequence
  sequence rdSta;
    sfrRead && !sfrWrite && sfrAddr == mae_pkg::ADDR_STATUS;
  endsequence
  sequence wrCfg;
    sfrWrite && sfrAddr == mae_pkg::ADDR_CFG;
  endsequence
  sequence armShift;
    wrCfg ##0 sfrWdata[mae_pkg::CFG_SHIFT_REQ]
              && !sfrWdata[mae_pkg::CFG_CLEAR];
  endsequence
  sequence armClear;
    wrCfg ##0 sfrWdata[mae_pkg::CFG_CLEAR];
  endsequence

  a_cfg_pad_zero: assert property (rdCfg |=> sfrRdata[7:6] == 2'h0)
    else $error("config unused bits read non-zero");
  a_sta_pad_zero: assert property (rdSta |=> sfrRdata[7:4] == 4'h0)
    else $error("status unused bits read non-zero");
  a_cfg_keeps_value: assert property (
    (wrCfg ##0 !sfrWdata[mae_pkg::CFG_SHIFT_REQ]
     && !sfrWdata[mae_pkg::CFG_CLEAR] ##1 rdCfg)
    |=> sfrRdata == ($past(sfrWdata, 2) & 8'h3f))
    else $error("config read differs from written mode bits");
  a_shift_self_clear: assert property (
    (armShift ##1 !sfrWrite ##1 rdCfg) |=> !sfrRdata[mae_pkg::CFG_SHIFT_REQ])
    else $error("shift request bit did not clear");
  a_clear_self_clear: assert property (
    (armClear ##1 !sfrWrite ##1 rdCfg) |=> !sfrRdata[mae_pkg::CFG_CLEAR])
    else $error("clear bit did not clear");
  a_clear_resets_flags: assert property (
    (armClear ##1 !sfrWrite ##1 rdSta)
    |=> sfrRdata == {4'h0, mae_pkg::STA_RESET})
    else $error("clear left status flags set");
  a_shift_keeps_flags: assert property (
    (rdSta ##2 armShift ##1 !sfrWrite ##1 rdSta)
    |=> sfrRdata == $past(sfrRdata, 4))
    else $error("shift changed status flags");
  a_read_data_holds: assert property (!sfrRead |=> $stable(sfrRdata))
    else $error("read data moved without a read");
endmodule
bind mae_engine mae_engine_asserts mae_engine_asserts_i (
  .clock(clock), .rst_b(rst_b), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
  .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata));
`default_nettype wire

// ==== dv/mae_core_model.sv ====
/*
  Core side of the register bus: one-cycle write and read strobes.
  Assumes inputs change at the falling edge and the engine samples rising.
*/
`timescale 1ns/1ps
`default_nettype none
module mae_core_model (
  // clock
  input  wire logic       clock,
  // register bus
  output var  logic [7:0] sfrAddr,
  output var  logic       sfrWrite,
  output var  logic       sfrRead,
  output var  logic [7:0] sfrWdata,
  input  wire logic [7:0] sfrRdata
);
  initial begin
    sfrAddr  = 8'h00;
    sfrWrite = 1'b0;
    sfrRead  = 1'b0;
    sfrWdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfrAddr  = a;
    sfrWdata = d;
    sfrRead  = 1'b0;
    sfrWrite = 1'b1;
  endtask
  // released lines show the inverse of their last value
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    sfrAddr  = a;
    sfrWrite = 1'b0;
    sfrRead  = 1'b1;
    @(negedge clock);
    sfrRead  = 1'b0;
    sfrAddr  = ~a;
    sfrWdata = ~sfrWdata;
    d        = sfrRdata;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clock);
      sfrWrite = 1'b0;
      sfrRead  = 1'b0;
      sfrAddr  = ~sfrAddr;
      sfrWdata = ~sfrWdata;
    end
  endtask
endmodule
`default_nettype wire

// ==== dv/mac_engine_registers_tb.sv ====
/*
  Self-checking bench for the multiply-accumulate engine.
  Assumes mae_core_model drives the register bus and the checker is bound.
*/
`timescale 1ns/1ps
`default_nettype none
module mac_engine_registers_tb;
  logic       clock;
  logic       rst_b;
  logic [7:0] sfrAddr;
  logic       sfrWrite;
  logic       sfrRead;
  logic [7:0] sfrWdata;
  logic [7:0] sfrRdata;
  int         nMismatch = 0;
  int         compares = 0;

  mae_engine mae_engine_i (.clock(clock), .rst_b(rst_b), .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata));
  mae_core_model mae_core_model_i (.clock(clock), .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata));

  initial clock = 1'b0;
  always #10 clock = ~clock;

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", compares, nMismatch);
    if (nMismatch == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic w(input logic [7:0] a, d);
    mae_core_model_i.wr(a, d);
  endtask
  task automatic idle(input int n);
    mae_core_model_i.idle(n);
  endtask
  task automatic rc(input logic [7:0] a, exp);
    logic [7:0] d;
    mae_core_model_i.rd(a, d);
    check($sformatf("reg %h", a), d, exp);
  endtask
  // byte 0 goes last so the rounding follows the whole value
  task automatic wacc(input logic [39:0] v);
    for (int i = 4; i >= 0; i--) w(mae_pkg::ACC_ADDRS[i], v[i*8 +: 8]);
  endtask
  task automatic racc(input logic [39:0] v);
    for (int i = 0; i < 5; i++) rc(mae_pkg::ACC_ADDRS[i], v[i*8 +: 8]);
  endtask
  task automatic rrnd(input logic [15:0] v);
    rc(mae_pkg::ADDR_RNDH, v[15:8]);
    rc(mae_pkg::ADDR_RNDL, v[7:0]);
  endtask
  task automatic op(input logic [15:0] a, b);
    w(mae_pkg::ADDR_AH, a[15:8]);
    w(mae_pkg::ADDR_AL, a[7:0]);
    w(mae_pkg::ADDR_BH, b[15:8]);
    w(mae_pkg::ADDR_BL, b[7:0]);
  endtask
  task automatic done(input string name);
    $display("test %s finished, mismatches %0d", name, nMismatch);
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    nMismatch++;
    $display("wrong value run length expected end seen still running");
    close_out();
  end

  initial begin
    rst_b = 1'b0;
    repeat (8) @(negedge clock);
    rst_b = 1'b1;
    rc(mae_pkg::ADDR_CFG, 8'h00);
    rc(mae_pkg::ADDR_STATUS, 8'h04);
    rc(mae_pkg::ADDR_AH, 8'h00);
    w(mae_pkg::ADDR_CFG, 8'hc7);
    rc(mae_pkg::ADDR_CFG, 8'h07);
    w(mae_pkg::ADDR_STATUS, 8'hf0);
    rc(mae_pkg::ADDR_STATUS, 8'h00);
    rc(8'h90, 8'h00);
    done("registers");
    w(mae_pkg::ADDR_CFG, 8'h0a);
    op(16'h4000, 16'h2000);
    idle(3);
    racc(40'h0010000000);
    rrnd(16'h1000);
    w(mae_pkg::ADDR_BH, 8'he0);
    w(mae_pkg::ADDR_BL, 8'h00);
    idle(3);
    racc(40'h0000000000);
    rc(mae_pkg::ADDR_STATUS, 8'h04);
    rc(mae_pkg::ADDR_CFG, 8'h02);
    done("fraction");
    w(mae_pkg::ADDR_CFG, 8'h01);
    op(16'h1234, 16'hfedc);
    op(16'h1234, 16'hfedc);
    idle(3);
    racc(40'hffffeb3cb0);
    rc(mae_pkg::ADDR_STATUS, 8'h01);
    rrnd(16'hffeb);
    rc(mae_pkg::ADDR_AL, 8'h34);
    rc(mae_pkg::ADDR_BH, 8'hfe);
    rc(mae_pkg::ADDR_BL, 8'hdc);
    done("multiply only");
    wacc(40'h4088442211);
    rc(mae_pkg::ADDR_STATUS, 8'h01);
    w(mae_pkg::ADDR_CFG, 8'h20);
    idle(1);
    rc(mae_pkg::ADDR_STATUS, 8'h01);
    racc(40'h8110884422);
    w(mae_pkg::ADDR_CFG, 8'h30);
    w(mae_pkg::ADDR_CFG, 8'h30);
    idle(1);
    rc(mae_pkg::ADDR_CFG, 8'h10);
    racc(40'he044221108);
    rrnd(16'h4422);
    done("shift");
    w(mae_pkg::ADDR_CFG, 8'h08);
    idle(1);
    rc(mae_pkg::ADDR_STATUS, 8'h04);
    w(mae_pkg::ADDR_CFG, 8'h08);
    idle(1);
    rc(mae_pkg::ADDR_CFG, 8'h00);
    racc(40'h0000000000);
    done("clear");
    w(mae_pkg::ADDR_CFG, 8'h04);
    wacc(40'h007fffffff);
    op(16'h0001, 16'h0001);
    idle(3);
    racc(40'h0080000000);
    rc(mae_pkg::ADDR_STATUS, 8'h02);
    rrnd(16'h7fff);
    op(16'hffff, 16'h0001);
    idle(3);
    rc(mae_pkg::ADDR_STATUS, 8'h00);
    w(mae_pkg::ADDR_CFG, 8'h00);
    wacc(40'h0080000000);
    idle(1);
    rrnd(16'h8000);
    done("soft overflow");
    w(mae_pkg::ADDR_CFG, 8'h04);
    wacc(40'h7fffffffff);
    op(16'h0001, 16'h0001);
    idle(3);
    rc(mae_pkg::ADDR_STATUS, 8'h0b);
    rc(mae_pkg::ADDR_TOP, 8'h80);
    rrnd(16'h8000);
    op(16'h0000, 16'h0000);
    idle(3);
    rc(mae_pkg::ADDR_STATUS, 8'h0b);
    w(mae_pkg::ADDR_STATUS, 8'h00);
    rc(mae_pkg::ADDR_STATUS, 8'h00);
    done("hard overflow");
    w(mae_pkg::ADDR_CFG, 8'h00);
    wacc(40'h0012358000);
    idle(1);
    rrnd(16'h1236);
    wacc(40'h0012348000);
    idle(1);
    rrnd(16'h1234);
    done("rounding");
    w(mae_pkg::ADDR_CFG, 8'h08);
    op(16'h0100, 16'h0002);
    w(mae_pkg::ADDR_BH, 8'h00);
    w(mae_pkg::ADDR_BL, 8'h03);
    idle(3);
    racc(40'h0000000500);
    rc(mae_pkg::ADDR_STATUS, 8'h00);
    done("pipeline");
    w(mae_pkg::ADDR_CFG, 8'h15);
    rc(mae_pkg::ADDR_CFG, 8'h15);
    @(negedge clock);
    rst_b = 1'b0;
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    rc(mae_pkg::ADDR_CFG, 8'h00);
    rc(mae_pkg::ADDR_STATUS, 8'h04);
    racc(40'h0000000000);
    done("reset");
    close_out();
  end
endmodule
`default_nettype wire
